// ===== hw/dib_consts.svh
// Notes on behaviour
// RULE1 - Auto mode copies process variable to output.
// RULE2 - Manual mode drives written value; PV tracks.
// RULE3 - Out of service: halt, bad status, flag.
// RULE4 - Resource auto and valid channel before leaving.
// RULE5 - Normal operation passes good non-cascade status.
// RULE6 - Simulation supplies field, PV and output status.
// RULE7 - Manual output status is good, constant.
// RULE8 - Channel 6 is switch one, 7 switch two.
// RULE9 - Two independent instances, each own channel.
// RULE10 - Invert option complements field value before PV.
// RULE11 - PV changes only after filter time held.
// RULE12 - Alarm compares final output, every execution.
// RULE13 - Invert only option; writable only out of service.
// RULE14 - Alarm when output equals limit; 255 disables.
// RULE15 - Error bit 1 for uninitialized channel.
// RULE16 - Error bit 3 while simulation enabled.
// RULE17 - Error bit 7 on input failure.
// RULE18 - Error bit 14 from power-up until running.
// RULE19 - Error bit 15 while out of service.
// RULE20 - Other error bits held cleared.
// RULE21 - Hardware failure bad; transducer off bad out-of-service.
// RULE22 - Simulation only enabled while jumper asserted.
// RULE23 - Mode bits: 7 out of service, 4 manual, 3 auto.
// RULE24 - Filter counts while different, restarts when equal.
`ifndef DIB_CONSTS_SVH
`define DIB_CONSTS_SVH
`define DIB_IDX_TARGET 4'h0
`define DIB_IDX_ACTUAL 4'h1
`define DIB_IDX_PERMIT 4'h2
`define DIB_IDX_CHAN   4'h3
`define DIB_IDX_OPTS   4'h4
`define DIB_IDX_FTIME  4'h5
`define DIB_IDX_LIMIT  4'h6
`define DIB_IDX_MAN    4'h7
`define DIB_IDX_SIM    4'h8
`define DIB_IDX_BLKERR 4'h9
`define DIB_IDX_OUT    4'ha
`define DIB_IDX_PV     4'hb
`define DIB_WA_GLOBAL  6'h20
`define DIB_A_WORD     7:2
`define DIB_A_GLOB     5
`define DIB_A_INST     4
`define DIB_A_IDX      3:0
`define DIB_D_BYTE     7:0
`define DIB_D_HALF     15:0
`define DIB_D_SIMEN    16
`define DIB_D_INV      0
`define DIB_D_RES      0
`define DIB_MODE_OOS   8'h80
`define DIB_MODE_MAN   8'h10
`define DIB_MODE_AUTO  8'h08
`define DIB_PERMIT_RST 8'h98
`define DIB_CH_SW1     8'h06
`define DIB_CH_SW2     8'h07
`define DIB_ST_GOOD    8'h80
`define DIB_ST_CONST   8'h83
`define DIB_ST_BAD     8'h00
`define DIB_ST_BAD_OOS 8'h1c
`define DIB_LIM_OFF    8'hff
`define DIB_BE_CFG     1
`define DIB_BE_SIM     3
`define DIB_BE_INPUT   7
`define DIB_BE_PWRUP   14
`define DIB_BE_OOS     15
`define DIB_BE_USED    16'hc08a
`endif

// ===== hw/dib_pkg.sv
package dib_pkg;
  typedef enum logic [2:0] {
    DIB_OOS  = 3'b001,
    DIB_MAN  = 3'b010,
    DIB_AUTO = 3'b100
  } dib_mode_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] value;
  } dib_sig_t;
  typedef struct packed {
    logic     alarm;
    dib_sig_t out;
  } dib_out_t;
endpackage

// ===== hw/dib_top.sv
`timescale 1ns/10ps
`include "dib_consts.svh"
module dib_top (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Transducer readbacks and health
  input  wire logic                  switch_one_readback,
  input  wire logic                  switch_two_readback,
  input  wire logic                  input_hw_fail,
  input  wire logic                  xd_out_of_service,
  // Simulate-enable jumper pin
  input  wire logic                  sim_jumper,
  // Block outputs, one per instance
  output dib_pkg::dib_out_t [1:0]    block_out
);

  function automatic logic [7:0] dib_inv(input logic [7:0] v);
    dib_inv = (v == 8'h00) ? 8'h01 : 8'h00;
  endfunction

  function automatic logic dib_chan_ok(input logic [7:0] c);
    dib_chan_ok = (c == `DIB_CH_SW1) || (c == `DIB_CH_SW2);
  endfunction

  logic                 j_s1_r;
  logic                 j_s2_r;
  logic                 j_s3_r;
  logic                 jumper_r;
  logic                 res_auto_r;
  logic                 wr_pend_r;
  logic [5:0]           wr_addr_r;
  logic [7:0]           target_r [2];
  logic [7:0]           permit_r [2];
  logic [7:0]           chan_r   [2];
  logic [7:0]           lim_r    [2];
  logic                 opts_r   [2];
  logic [15:0]          ftime_r  [2];
  logic [15:0]          cnt_r    [2];
  logic                 sim_en_r [2];
  logic                 pwrup_r  [2];
  dib_pkg::dib_sig_t    man_r    [2];
  dib_pkg::dib_sig_t    sim_r    [2];
  dib_pkg::dib_sig_t    field_r  [2];
  dib_pkg::dib_sig_t    pv_r     [2];
  dib_pkg::dib_mode_t   mode_r   [2];
  dib_pkg::dib_mode_t   mode_nxt [2];
  dib_pkg::dib_sig_t    field_nxt[2];
  dib_pkg::dib_sig_t    out_nxt  [2];
  logic [7:0]           proc_val [2];
  logic                 sim_act  [2];
  logic [15:0]          blkerr   [2];
  logic [31:0]          rd_word;
  logic                 addr_ok;
  logic [5:0]           ra;
  logic [5:0]           wa;

  assign addr_ok = hsel && htrans[1] && hready;
  assign ra      = haddr[`DIB_A_WORD];
  assign wa      = wr_addr_r;

  // The first stage feeds only the second; a change counts once two and three agree.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      j_s1_r   <= 1'b0;
      j_s2_r   <= 1'b0;
      j_s3_r   <= 1'b0;
      jumper_r <= 1'b0;
    end else begin
      j_s1_r <= sim_jumper;
      j_s2_r <= j_s1_r;
      j_s3_r <= j_s2_r;
      if (j_s2_r == j_s3_r) begin
        jumper_r <= j_s3_r;
      end
    end
  end

  // Zero-wait slave: read data is registered at the address phase edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 6'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= ra;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (ra == `DIB_WA_GLOBAL) begin
      rd_word[`DIB_D_RES] = res_auto_r;
    end else if (!ra[`DIB_A_GLOB]) begin
      for (int i = 0; i < 2; i++) begin
        if (ra[`DIB_A_INST] == i[0]) begin
          case (ra[`DIB_A_IDX])
            `DIB_IDX_TARGET: rd_word[`DIB_D_BYTE] = target_r[i];
            `DIB_IDX_ACTUAL: rd_word[`DIB_D_BYTE] = (mode_r[i] == dib_pkg::DIB_OOS) ?
                `DIB_MODE_OOS : (mode_r[i] == dib_pkg::DIB_MAN) ? // RULE23
                `DIB_MODE_MAN : `DIB_MODE_AUTO;
            `DIB_IDX_PERMIT: rd_word[`DIB_D_BYTE] = permit_r[i];
            `DIB_IDX_CHAN:   rd_word[`DIB_D_BYTE] = chan_r[i];
            `DIB_IDX_OPTS:   rd_word[`DIB_D_INV] = opts_r[i];
            `DIB_IDX_FTIME:  rd_word[`DIB_D_HALF] = ftime_r[i];
            `DIB_IDX_LIMIT:  rd_word[`DIB_D_BYTE] = lim_r[i];
            `DIB_IDX_MAN:    rd_word[`DIB_D_HALF] = man_r[i];
            `DIB_IDX_SIM: begin
              rd_word[`DIB_D_HALF]  = sim_r[i];
              rd_word[`DIB_D_SIMEN] = sim_en_r[i];
            end
            `DIB_IDX_BLKERR: rd_word[`DIB_D_HALF] = blkerr[i];
            `DIB_IDX_OUT:    rd_word = {15'h0000, block_out[i]};
            `DIB_IDX_PV:     rd_word = {field_r[i], pv_r[i]};
            default:         rd_word = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Configuration written by software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_auto_r <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        target_r[i] <= `DIB_MODE_OOS;
        permit_r[i] <= `DIB_PERMIT_RST;
        chan_r[i]   <= 8'h00;
        lim_r[i]    <= `DIB_LIM_OFF;
        opts_r[i]   <= 1'b0;
        ftime_r[i]  <= 16'h0000;
        man_r[i]    <= 16'h0000;
        sim_r[i]    <= 16'h0000;
        sim_en_r[i] <= 1'b0;
      end
    end else begin
      if (wr_pend_r && wa == `DIB_WA_GLOBAL) begin
        res_auto_r <= hwdata[`DIB_D_RES];
      end
      for (int i = 0; i < 2; i++) begin
        if (!jumper_r) begin
          sim_en_r[i] <= 1'b0; // RULE22
        end
        if (wr_pend_r && !wa[`DIB_A_GLOB] && wa[`DIB_A_INST] == i[0]) begin
          case (wa[`DIB_A_IDX])
            `DIB_IDX_TARGET: begin
              if (hwdata[`DIB_D_BYTE] != 8'h00 &&
                  (hwdata[`DIB_D_BYTE] & ~permit_r[i]) == 8'h00) begin
                target_r[i] <= hwdata[`DIB_D_BYTE];
              end
            end
            `DIB_IDX_PERMIT: permit_r[i] <= hwdata[`DIB_D_BYTE];
            `DIB_IDX_CHAN:   chan_r[i] <= hwdata[`DIB_D_BYTE];
            `DIB_IDX_OPTS: begin
              if (mode_r[i] == dib_pkg::DIB_OOS) begin
                opts_r[i] <= hwdata[`DIB_D_INV]; // RULE13
              end
            end
            `DIB_IDX_FTIME:  ftime_r[i] <= hwdata[`DIB_D_HALF];
            `DIB_IDX_LIMIT:  lim_r[i] <= hwdata[`DIB_D_BYTE];
            `DIB_IDX_MAN:    man_r[i] <= hwdata[`DIB_D_HALF];
            `DIB_IDX_SIM: begin
              sim_r[i]    <= hwdata[`DIB_D_HALF];
              sim_en_r[i] <= hwdata[`DIB_D_SIMEN] && jumper_r; // RULE22
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Per-instance signal path, evaluated every clock.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sim_act[i] = sim_en_r[i] && jumper_r;
      field_nxt[i].value = 8'h00;
      if (chan_r[i] == `DIB_CH_SW1) begin
        field_nxt[i].value = {7'h00, switch_one_readback}; // RULE8 RULE9
      end else if (chan_r[i] == `DIB_CH_SW2) begin
        field_nxt[i].value = {7'h00, switch_two_readback}; // RULE8 RULE9
      end
      if (xd_out_of_service) begin
        field_nxt[i].status = `DIB_ST_BAD_OOS; // RULE21
      end else if (input_hw_fail) begin
        field_nxt[i].status = `DIB_ST_BAD; // RULE21
      end else begin
        field_nxt[i].status = `DIB_ST_GOOD; // RULE5
      end
      if (sim_act[i]) begin
        field_nxt[i] = sim_r[i]; // RULE6
      end
      proc_val[i] = opts_r[i] ? dib_inv(field_r[i].value) : field_r[i].value; // RULE10
      // A target holding several bits settles on the most restrictive one.
      if ((target_r[i] & `DIB_MODE_OOS) != 8'h00 || !res_auto_r ||
          !dib_chan_ok(chan_r[i])) begin
        mode_nxt[i] = dib_pkg::DIB_OOS; // RULE4
      end else if ((target_r[i] & `DIB_MODE_MAN) != 8'h00) begin
        mode_nxt[i] = dib_pkg::DIB_MAN;
      end else if ((target_r[i] & `DIB_MODE_AUTO) != 8'h00) begin
        mode_nxt[i] = dib_pkg::DIB_AUTO;
      end else begin
        mode_nxt[i] = dib_pkg::DIB_OOS;
      end
      case (mode_r[i])
        dib_pkg::DIB_OOS: begin
          out_nxt[i].value  = block_out[i].out.value;
          out_nxt[i].status = `DIB_ST_BAD_OOS; // RULE3
        end
        dib_pkg::DIB_MAN: begin
          out_nxt[i].value  = man_r[i].value; // RULE2
          out_nxt[i].status = `DIB_ST_CONST; // RULE7
        end
        dib_pkg::DIB_AUTO: begin
          out_nxt[i] = pv_r[i]; // RULE1 RULE5 RULE6
        end
        default: begin
          out_nxt[i].value  = block_out[i].out.value;
          out_nxt[i].status = `DIB_ST_BAD_OOS;
        end
      endcase
      blkerr[i] = 16'h0000; // RULE20
      blkerr[i][`DIB_BE_CFG]   = !dib_chan_ok(chan_r[i]); // RULE15
      blkerr[i][`DIB_BE_SIM]   = sim_act[i]; // RULE16
      blkerr[i][`DIB_BE_INPUT] = input_hw_fail || xd_out_of_service; // RULE17
      blkerr[i][`DIB_BE_PWRUP] = pwrup_r[i]; // RULE18
      blkerr[i][`DIB_BE_OOS]   = (mode_r[i] == dib_pkg::DIB_OOS); // RULE19
    end
  end

  // Mode, filter, process variable and output registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        mode_r[i]    <= dib_pkg::DIB_OOS;
        pwrup_r[i]   <= 1'b1;
        field_r[i]   <= {`DIB_ST_BAD_OOS, 8'h00};
        pv_r[i]      <= {`DIB_ST_BAD_OOS, 8'h00};
        cnt_r[i]     <= 16'h0000;
        block_out[i] <= {1'b0, `DIB_ST_BAD_OOS, 8'h00};
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        mode_r[i] <= mode_nxt[i];
        if (mode_r[i] != dib_pkg::DIB_OOS) begin
          pwrup_r[i] <= 1'b0; // RULE18
        end
        // Processing halts out of service so field, PV and output value hold.
        if (mode_r[i] != dib_pkg::DIB_OOS) begin
          field_r[i]        <= field_nxt[i];
          pv_r[i].status    <= field_r[i].status; // RULE6 RULE21
          if (proc_val[i] == pv_r[i].value) begin
            cnt_r[i] <= 16'h0000; // RULE24
          end else if (cnt_r[i] >= ftime_r[i]) begin
            pv_r[i].value <= proc_val[i]; // RULE11
            cnt_r[i]      <= 16'h0000;
          end else begin
            cnt_r[i] <= cnt_r[i] + 16'h0001; // RULE24
          end
        end
        block_out[i].out   <= out_nxt[i];
        block_out[i].alarm <= (lim_r[i] != `DIB_LIM_OFF) &&
                              (out_nxt[i].value == lim_r[i]); // RULE12 RULE14
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_auto_out_pv: assert property ((mode_r[0] == dib_pkg::DIB_AUTO) |=> // RULE1
    block_out[0].out == $past(pv_r[0])) else $error("auto output not pv");
  a_man_value: assert property ((mode_r[1] == dib_pkg::DIB_MAN) |=> // RULE2
    block_out[1].out.value == $past(man_r[1].value)) else $error("manual value lost");
  a_man_status: assert property ((mode_r[0] == dib_pkg::DIB_MAN) |=> // RULE7
    block_out[0].out.status == `DIB_ST_CONST) else $error("manual status wrong");
  a_oos_status: assert property ((mode_r[0] == dib_pkg::DIB_OOS) |-> // RULE3
    blkerr[0][`DIB_BE_OOS] ##1 block_out[0].out.status == `DIB_ST_BAD_OOS)
    else $error("oos status wrong");
  a_sim_field: assert property ((sim_act[0] && mode_r[0] != dib_pkg::DIB_OOS) |=> // RULE6
    field_r[0].status == $past(sim_r[0].status)) else $error("sim status not used");
  a_cfg_err: assert property (!dib_chan_ok(chan_r[0]) |-> // RULE15
    blkerr[0][`DIB_BE_CFG] ##1 mode_r[0] == dib_pkg::DIB_OOS) else $error("cfg error missed");
  a_sim_err: assert property (sim_act[1] |-> blkerr[1][`DIB_BE_SIM]) // RULE16
    else $error("sim error bit missing");
  a_input_err: assert property ((input_hw_fail || xd_out_of_service) |-> // RULE17
    blkerr[0][`DIB_BE_INPUT]) else $error("input error bit missing");
  a_pwrup_clear: assert property ((mode_r[0] != dib_pkg::DIB_OOS) |=> // RULE18
    !pwrup_r[0] && !blkerr[0][`DIB_BE_PWRUP]) else $error("power-up bit stuck");
  a_err_unused: assert property ((blkerr[1] & ~`DIB_BE_USED) == 16'h0000) // RULE20
    else $error("unused error bit set");
  a_alarm_match: assert property (block_out[0].alarm |-> // RULE14
    $past(lim_r[0]) != `DIB_LIM_OFF && block_out[0].out.value == $past(lim_r[0]))
    else $error("alarm without match");
  a_filter_hold: assert property ($changed(pv_r[0].value) |-> // RULE11
    $past(cnt_r[0]) >= $past(ftime_r[0])) else $error("pv changed early");
  a_sim_gate: assert property ($rose(sim_en_r[0]) |-> $past(jumper_r)) // RULE22
    else $error("sim enabled without jumper");
  a_opts_lock: assert property ($changed(opts_r[1]) |-> // RULE13
    $past(mode_r[1]) == dib_pkg::DIB_OOS) else $error("options written in service");

  c_auto_run: cover property (mode_r[0] == dib_pkg::DIB_AUTO ##1 $changed(pv_r[0].value));
  c_manual: cover property (mode_r[1] == dib_pkg::DIB_MAN);
  c_sim: cover property (sim_act[0] && mode_r[0] == dib_pkg::DIB_AUTO);
  c_alarm: cover property ($rose(block_out[0].alarm));

endmodule

// ===== dv/dib_xd_model.sv
`timescale 1ns/10ps
// Transducer side: readbacks and health flags launch one clock after the bench asks.
module dib_xd_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Requests from the bench
  input  wire logic [1:0] sw_cmd,
  input  wire logic       fail_cmd,
  input  wire logic       xoos_cmd,
  // Transducer outputs
  output logic            switch_one_readback,
  output logic            switch_two_readback,
  output logic            input_hw_fail,
  output logic            xd_out_of_service
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_one_readback <= 1'b0;
      switch_two_readback <= 1'b0;
    end else begin
      switch_one_readback <= sw_cmd[0];
      switch_two_readback <= sw_cmd[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_hw_fail     <= 1'b0;
      xd_out_of_service <= 1'b0;
    end else begin
      input_hw_fail     <= fail_cmd;
      xd_out_of_service <= xoos_cmd;
    end
  end
endmodule

// ===== dv/discrete_input_block_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module discrete_input_block_bench;
  logic                    hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic                    sim_jumper, fail_cmd, xoos_cmd, sw1, sw2, hw_fail, xd_oos;
  logic [1:0]              htrans, sw_cmd, lv;
  logic [2:0]              hsize;
  logic [31:0]             haddr, hwdata, hrdata, seed, rdv;
  dib_pkg::dib_out_t [1:0] block_out;
  int                      errors, total_checks, g;

  dib_xd_model xd (.hclk(hclk), .hresetn(hresetn), .sw_cmd(sw_cmd), .fail_cmd(fail_cmd),
    .xoos_cmd(xoos_cmd), .switch_one_readback(sw1), .switch_two_readback(sw2),
    .input_hw_fail(hw_fail), .xd_out_of_service(xd_oos));
  dib_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .switch_one_readback(sw1),
    .switch_two_readback(sw2), .input_hw_fail(hw_fail), .xd_out_of_service(xd_oos),
    .sim_jumper(sim_jumper), .block_out(block_out));
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Instance zero inverts its switch and alarms on 1; instance one never alarms.
  function automatic logic [16:0] exp_out(input int i, input logic s);
    logic [7:0] v;
    v = (i == 0) ? {7'h00, ~s} : {7'h00, s};
    return {(i == 0) && (v == 8'h01), 8'h80, v};
  endfunction

  task automatic stop_test();
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= 3'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    htrans <= 2'b00; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
    rdv = hrdata;
    if (n >= 64) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register", e, rdv)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic outs(input logic [1:0] s);
    `CHK("out0", exp_out(0, s[0]), block_out[0])
    `CHK("out1", exp_out(1, s[1]), block_out[1])
  endtask

  initial begin
    seed = 32'd98409; errors = 0; total_checks = 0;
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; sim_jumper = 1'b0; sw_cmd = 2'b00;
    fail_cmd = 1'b0; xoos_cmd = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    rchk(32'h00, 32'h80);
    rchk(32'h08, 32'h98);
    rchk(32'h04, 32'h80);
    rchk(32'h24, 32'hc002);
    rchk(32'h3c, 32'h0);
    `CHK("out0", 17'h01c00, block_out[0])
    wr(32'h10, 32'h1);
    wr(32'h14, 32'h4);
    wr(32'h18, 32'h1);
    wr(32'h54, 32'h4);
    wr(32'h00, 32'h08);
    wr(32'h40, 32'h08);
    wr(32'h0c, 32'h06);
    wr(32'h4c, 32'h07);
    cyc(3);
    rchk(32'h04, 32'h80);
    wr(32'h80, 32'h1);
    cyc(3);
    rchk(32'h04, 32'h08);
    rchk(32'h24, 32'h0);
    wr(32'h10, 32'h0);
    rchk(32'h10, 32'h1);
    for (int k = 0; k < 24; k++) begin
      void'(rnd());
      lv = seed[1:0];
      sw_cmd <= lv;
      cyc(12);
      outs(lv);
      g = 1 + rnd() % 3;
      sw_cmd <= ~lv;
      cyc(g);
      sw_cmd <= lv;
      cyc(12);
      outs(lv);
    end
    wr(32'h5c, 32'h0001);
    wr(32'h40, 32'h10);
    sw_cmd <= 2'b00;
    cyc(12);
    `CHK("out1", 17'h08301, block_out[1])
    rchk(32'h6c, 32'h80008000);
    sw_cmd <= 2'b10;
    cyc(12);
    rchk(32'h6c, 32'h80018001);
    `CHK("out1", 17'h08301, block_out[1])
    wr(32'h40, 32'h08);
    wr(32'h20, 32'h18c01);
    cyc(4);
    rchk(32'h24, 32'h0);
    sim_jumper <= 1'b1;
    cyc(8);
    wr(32'h20, 32'h18c01);
    cyc(12);
    rchk(32'h24, 32'h8);
    rchk(32'h2c, 32'h8c018c00);
    `CHK("out0", 17'h08c00, block_out[0])
    sim_jumper <= 1'b0;
    cyc(12);
    rchk(32'h24, 32'h0);
    `CHK("out0", 17'h18001, block_out[0])
    fail_cmd <= 1'b1;
    cyc(6);
    `CHK("status", 8'h00, block_out[0].out.status)
    rchk(32'h24, 32'h80);
    xoos_cmd <= 1'b1;
    cyc(6);
    `CHK("status", 8'h1c, block_out[0].out.status)
    fail_cmd <= 1'b0;
    xoos_cmd <= 1'b0;
    cyc(6);
    `CHK("status", 8'h80, block_out[0].out.status)
    wr(32'h00, 32'h80);
    cyc(4);
    rchk(32'h04, 32'h80);
    rchk(32'h24, 32'h8000);
    `CHK("out0", 17'h11c01, block_out[0])
    wr(32'h00, 32'h04);
    rchk(32'h00, 32'h80);
    wr(32'h4c, 32'h0b);
    cyc(3);
    rchk(32'h64, 32'h8002);
    stop_test();
  end
endmodule
